// file: design/spicc_top.sv
// serial port control register one with its clock, select and data pins
// assumes an AXI4-Lite master on i_clk_sys; link pins arrive asynchronously
//
// The implementer's own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "spicc_cfg.svh"

module spicc_top
	import spicc_pkg::*;
#(
	parameter int HALF_DIV = `SPICC_HALF_DIV
)
(
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire spicc_pkg::spicc_addr_type i_awaddr,
	input wire logic i_wvalid,
	output logic o_wready,
	input wire spicc_pkg::spicc_bus_word_type i_wdata,
	input wire logic [3:0] i_wstrb,
	output logic o_bvalid,
	input wire logic i_bready,
	output logic [1:0] o_bresp,
	input wire logic i_arvalid,
	output logic o_arready,
	input wire spicc_pkg::spicc_addr_type i_araddr,
	output logic o_rvalid,
	input wire logic i_rready,
	output spicc_pkg::spicc_bus_word_type o_rdata,
	output logic [1:0] o_rresp,
	input wire logic i_sclk,
	output logic o_sclk,
	output logic o_sclk_oe,
	input wire logic i_sdi,
	output logic o_sdo,
	output logic o_sdo_oe,
	input wire logic i_ss_n,
	output logic o_ss_in_use
);
	import spicc_pkg::*;

	localparam logic [15:0] HALF_CNT = 16'(HALF_DIV - 1);

	spicc_word_type ctrl_q;
	spicc_word_type tx_q;
	spicc_word_type rx_word;
	spicc_addr_type aw_addr_q;
	spicc_bus_word_type w_data_q;
	logic [3:0] w_strb_q;
	logic aw_held_q;
	logic w_held_q;
	logic wr_go;
	logic wr_ctrl;
	logic wr_data;
	logic rd_go;
	logic rd_data;
	logic rx_full_q;
	logic load_q;

	logic master;
	logic clock_idle_polarity;
	logic cke;
	logic w16;
	logic slave_select_use;
	logic do_rel;
	logic clk_rel;

	logic sclk_s1_q;
	logic sclk_s2_q;
	logic sclk_s3_q;
	logic sdi_s1_q;
	logic sdi_s2_q;
	logic ss_s1_q;
	logic ss_s2_q;
	logic ss_s3_q;

	spicc_link_state_type link_q;
	logic [15:0] div_q;
	logic [5:0] edge_q;
	logic [5:0] edges_total;
	logic active_q;
	logic m_lead_q;
	logic m_trail_q;
	logic s_level;
	logic s_level_prev;
	logic s_sel;
	logic s_lead;
	logic s_trail;
	logic lead;
	logic trail;
	logic abort;
	logic busy;
	logic done;

	assign master = ctrl_q[`SPICC_BIT_MASTER_ROLE_ENABLE];
	assign clock_idle_polarity = ctrl_q[`SPICC_BIT_CKP];
	assign cke = ctrl_q[`SPICC_BIT_CKE];
	assign w16 = ctrl_q[`SPICC_BIT_W16];
	assign slave_select_use = ctrl_q[`SPICC_BIT_SLAVE_SELECT_USE];
	assign do_rel = ctrl_q[`SPICC_BIT_DO_REL];
	assign clk_rel = ctrl_q[`SPICC_BIT_CLK_REL];

	// write channel: address and data may come in either order
	assign o_awready = ~aw_held_q & ~o_bvalid;
	assign o_wready = ~w_held_q & ~o_bvalid;
	assign wr_go = aw_held_q & w_held_q & ~o_bvalid;
	assign wr_ctrl = wr_go && (aw_addr_q == `SPICC_OFS_CTRL);
	assign wr_data = wr_go && (aw_addr_q == `SPICC_OFS_DATA);

	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			aw_held_q <= 1'b0;
			aw_addr_q <= '0;
		end
		else if (i_awvalid && o_awready)
		begin
			aw_held_q <= 1'b1;
			aw_addr_q <= i_awaddr;
		end
		else if (wr_go)
		begin
			aw_held_q <= 1'b0;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			w_held_q <= 1'b0;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
		end
		else if (i_wvalid && o_wready)
		begin
			w_held_q <= 1'b1;
			w_data_q <= i_wdata;
			w_strb_q <= i_wstrb;
		end
		else if (wr_go)
		begin
			w_held_q <= 1'b0;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_bvalid <= 1'b0;
			o_bresp <= `SPICC_RESP_OKAY;
		end
		else if (wr_go)
		begin
			o_bvalid <= 1'b1;
			o_bresp <= (wr_ctrl || wr_data || aw_addr_q == `SPICC_OFS_STAT) ?
				`SPICC_RESP_OKAY : `SPICC_RESP_SLVERR;
		end
		else if (i_bready)
		begin
			o_bvalid <= 1'b0;
		end
	end

	// control register, byte lanes honoured; bits 15:13 stay zero
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			ctrl_q <= `SPICC_CTRL_RST;
		end
		else if (wr_ctrl)
		begin
			if (w_strb_q[0])
			begin
				ctrl_q[7:0] <= w_data_q[7:0];
			end
			if (w_strb_q[1])
			begin
				ctrl_q[15:8] <= w_data_q[15:8] & 8'(`SPICC_CTRL_MASK >> 8);
			end
		end
	end

	// a data write while a word is in flight is dropped, not queued
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			tx_q <= 16'h0000;
			load_q <= 1'b0;
		end
		else
		begin
			load_q <= 1'b0;
			if (wr_data && !busy && !load_q && w_strb_q != 4'h0)
			begin
				tx_q <= w_data_q[15:0];
				load_q <= 1'b1;
			end
		end
	end

	// read channel
	assign o_arready = ~o_rvalid;
	assign rd_go = i_arvalid & o_arready;
	assign rd_data = rd_go && (i_araddr == `SPICC_OFS_DATA);

	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_rvalid <= 1'b0;
			o_rdata <= 32'h0000_0000;
			o_rresp <= `SPICC_RESP_OKAY;
		end
		else if (rd_go)
		begin
			o_rvalid <= 1'b1;
			o_rresp <= `SPICC_RESP_OKAY;
			case (i_araddr)
				`SPICC_OFS_CTRL: o_rdata <= {16'h0000, ctrl_q};
				`SPICC_OFS_DATA: o_rdata <= {16'h0000, rx_word};
				`SPICC_OFS_STAT: o_rdata <= {30'h0000_0000, rx_full_q, busy};
				default:
				begin
					o_rdata <= 32'h0000_0000;
					o_rresp <= `SPICC_RESP_SLVERR;
				end
			endcase
		end
		else if (i_rready)
		begin
			o_rvalid <= 1'b0;
		end
	end

	// received-word flag: a completion in the clearing cycle wins
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			rx_full_q <= 1'b0;
		end
		else if (done)
		begin
			rx_full_q <= 1'b1;
		end
		else if (rd_data)
		begin
			rx_full_q <= 1'b0;
		end
	end

	// pin synchronisers; only the second stage onward feeds logic
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			sclk_s1_q <= 1'b0;
			sclk_s2_q <= 1'b0;
			sclk_s3_q <= 1'b0;
			sdi_s1_q <= 1'b0;
			sdi_s2_q <= 1'b0;
			ss_s1_q <= 1'b1;
			ss_s2_q <= 1'b1;
			ss_s3_q <= 1'b1;
		end
		else
		begin
			sclk_s1_q <= i_sclk;
			sclk_s2_q <= sclk_s1_q;
			sclk_s3_q <= sclk_s2_q;
			sdi_s1_q <= i_sdi;
			sdi_s2_q <= sdi_s1_q;
			ss_s1_q <= i_ss_n;
			ss_s2_q <= ss_s1_q;
			ss_s3_q <= ss_s2_q;
		end
	end

	// master clock generator: 2*n edges per word, idle level from polarity
	assign edges_total = w16 ? 6'(`SPICC_BITS_WORD << 1) : 6'(`SPICC_BITS_BYTE << 1);

	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			link_q <= LINK_IDLE;
			div_q <= 16'h0000;
			edge_q <= 6'h00;
			active_q <= 1'b0;
			m_lead_q <= 1'b0;
			m_trail_q <= 1'b0;
		end
		else
		begin
			m_lead_q <= 1'b0;
			m_trail_q <= 1'b0;
			case (link_q)
				LINK_IDLE:
				begin
					active_q <= 1'b0;
					div_q <= 16'h0000;
					edge_q <= 6'h00;
					if (load_q && master)
					begin
						link_q <= LINK_RUN;
					end
				end
				LINK_RUN:
				begin
					if (!master)
					begin
						link_q <= LINK_IDLE;
					end
					else if (div_q == HALF_CNT)
					begin
						div_q <= 16'h0000;
						active_q <= ~active_q;
						m_lead_q <= ~active_q;
						m_trail_q <= active_q;
						edge_q <= edge_q + 6'h01;
						if (edge_q == edges_total - 6'h01)
						begin
							link_q <= LINK_IDLE;
						end
					end
					else
					begin
						div_q <= div_q + 16'h0001;
					end
				end
				default:
				begin
					link_q <= LINK_IDLE;
				end
			endcase
		end
	end

	// clock pin: idle level is the polarity bit, active is its inverse
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_sclk <= 1'b0;
			o_sclk_oe <= 1'b0;
		end
		else
		begin
			o_sclk <= clock_idle_polarity ^ active_q;
			o_sclk_oe <= master & ~clk_rel;
		end
	end

	// slave side: fold polarity so that 1 means the active level
	assign s_level = sclk_s2_q ^ clock_idle_polarity;
	assign s_level_prev = sclk_s3_q ^ clock_idle_polarity;
	// select honoured only in slave role with select use set
	assign s_sel = ~slave_select_use | ~ss_s2_q;
	assign s_lead = ~master & s_sel & s_level & ~s_level_prev;
	assign s_trail = ~master & s_sel & ~s_level & s_level_prev;
	assign lead = master ? m_lead_q : s_lead;
	assign trail = master ? m_trail_q : s_trail;
	// deselect in mid-word drops the partial word
	assign abort = ~master & slave_select_use & ss_s2_q & ~ss_s3_q;

	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_sdo_oe <= 1'b0;
			o_ss_in_use <= 1'b0;
		end
		else
		begin
			o_sdo_oe <= ~do_rel;
			o_ss_in_use <= ~master & slave_select_use;
		end
	end

	spicc_shift u_shift (
		.i_clk_sys(i_clk_sys),
		.i_rst_n(i_rst_n),
		.i_load(load_q),
		.i_abort(abort),
		.i_tx(tx_q),
		.i_width16(w16),
		.i_cke(cke),
		.i_lead(lead),
		.i_trail(trail),
		.i_sdi(sdi_s2_q),
		.o_sdo(o_sdo),
		.o_busy(busy),
		.o_done(done),
		.o_rx(rx_word)
	);
endmodule : spicc_top

`default_nettype wire

// file: design/spicc_cfg.svh
// register map, field positions, reset values and timing counts of the serial port
// included by the package and the design modules; defines only
`ifndef SPICC_CFG_SVH
`define SPICC_CFG_SVH

`define SPICC_ADDR_W 8
`define SPICC_OFS_CTRL 8'h00
`define SPICC_OFS_DATA 8'h04
`define SPICC_OFS_STAT 8'h08

`define SPICC_CTRL_RST 16'h0000
`define SPICC_CTRL_MASK 16'h1fff
`define SPICC_BIT_CLK_REL 12
`define SPICC_BIT_DO_REL 11
`define SPICC_BIT_W16 10
`define SPICC_BIT_SMP 9
`define SPICC_BIT_CKE 8
`define SPICC_BIT_SLAVE_SELECT_USE 7
`define SPICC_BIT_CKP 6
`define SPICC_BIT_MASTER_ROLE_ENABLE 5

`define SPICC_STAT_BUSY 0
`define SPICC_STAT_RXF 1

`define SPICC_BITS_WORD 6'h10
`define SPICC_BITS_BYTE 6'h08
`define SPICC_HALF_DIV 4

`define SPICC_RESP_OKAY 2'h0
`define SPICC_RESP_SLVERR 2'h2

`endif

// file: design/spicc_pkg.sv
// types shared by the serial port modules
// assumes spicc_cfg.svh is on the include path
`include "spicc_cfg.svh"

package spicc_pkg;
	typedef logic [15:0] spicc_word_type;
	typedef logic [31:0] spicc_bus_word_type;
	typedef logic [`SPICC_ADDR_W-1:0] spicc_addr_type;
	typedef enum logic {LINK_IDLE, LINK_RUN} spicc_link_state_type;
endpackage : spicc_pkg

// file: design/spicc_shift.sv
// shift engine: moves one 8 or 16 bit word out and in, msb first
// assumes edge pulses are one cycle wide and already synchronised to i_clk_sys
`timescale 1ns/1ps
`default_nettype none
`include "spicc_cfg.svh"

module spicc_shift
	import spicc_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_load,
	input wire logic i_abort,
	input wire spicc_pkg::spicc_word_type i_tx,
	input wire logic i_width16,
	input wire logic i_cke,
	input wire logic i_lead,
	input wire logic i_trail,
	input wire logic i_sdi,
	output logic o_sdo,
	output logic o_busy,
	output logic o_done,
	output spicc_pkg::spicc_word_type o_rx
);
	import spicc_pkg::*;

	spicc_word_type sh_q;
	spicc_word_type in_q;
	spicc_word_type sh_d;
	spicc_word_type in_d;
	logic [5:0] cnt_q;
	logic [5:0] nbits;
	logic skip_q;
	logic shift_ev;
	logic samp_ev;

	assign nbits = i_width16 ? `SPICC_BITS_WORD : `SPICC_BITS_BYTE;
	// data changes on active->idle when set, on idle->active when clear
	assign shift_ev = i_cke ? i_trail : i_lead;
	assign samp_ev = i_cke ? i_lead : i_trail;
	assign sh_d = {sh_q[14:0], 1'b0};
	assign in_d = {in_q[14:0], i_sdi};

	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			sh_q <= 16'h0000;
			o_sdo <= 1'b0;
			skip_q <= 1'b0;
		end
		else if (i_load)
		begin
			sh_q <= i_tx;
			o_sdo <= i_width16 ? i_tx[15] : i_tx[7];
			// with change on idle->active the first bit is already out
			skip_q <= ~i_cke;
		end
		else if (o_busy && shift_ev)
		begin
			if (skip_q)
			begin
				skip_q <= 1'b0;
			end
			else
			begin
				sh_q <= sh_d;
				o_sdo <= i_width16 ? sh_d[15] : sh_d[7];
			end
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_busy <= 1'b0;
			o_done <= 1'b0;
			cnt_q <= 6'h00;
			in_q <= 16'h0000;
			o_rx <= 16'h0000;
		end
		else
		begin
			o_done <= 1'b0;
			if (i_load)
			begin
				o_busy <= 1'b1;
				cnt_q <= 6'h00;
			end
			else if (i_abort)
			begin
				o_busy <= 1'b0;
			end
			else if (o_busy && samp_ev)
			begin
				in_q <= in_d;
				cnt_q <= cnt_q + 6'h01;
				if (cnt_q == nbits - 6'h01)
				begin
					o_busy <= 1'b0;
					o_done <= 1'b1;
					o_rx <= i_width16 ? in_d : {8'h00, in_d[7:0]};
				end
			end
		end
	end
endmodule : spicc_shift

`default_nettype wire

// file: tb/spicc_top_checker.sv
// assertions on the serial port top ports
// bound into spicc_top; assumes address and data of a write are offered together
`timescale 1ns/1ps
`default_nettype none
module spicc_top_checker
	import spicc_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_awvalid,
	input wire logic o_awready,
	input wire spicc_pkg::spicc_addr_type i_awaddr,
	input wire logic i_wvalid,
	input wire logic o_wready,
	input wire spicc_pkg::spicc_bus_word_type i_wdata,
	input wire logic o_bvalid,
	input wire logic [1:0] o_bresp,
	input wire logic i_arvalid,
	input wire logic o_arready,
	input wire logic o_rvalid,
	input wire logic i_rready,
	input wire spicc_pkg::spicc_bus_word_type o_rdata,
	input wire logic o_sclk,
	input wire logic o_sclk_oe,
	input wire logic o_sdo_oe,
	input wire logic o_ss_in_use
);
	logic [15:0] shd_q;
	logic [2:0] age_q;
	logic bad_q;
	wire take = i_awvalid && o_awready && i_wvalid && o_wready;
	wire wctl = take && i_awaddr == 8'h00;
	// pin checks wait a few cycles so the registered outputs have caught up
	wire calm = age_q == 3'h5;
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
		if (!i_rst_n) shd_q <= '0;
		else if (wctl) shd_q <= i_wdata[15:0] & 16'h1fff;
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
		if (!i_rst_n) age_q <= 3'h5;
		else if (wctl) age_q <= 3'h0;
		else if (!calm) age_q <= age_q + 3'h1;
	always_ff @(posedge i_clk_sys or negedge i_rst_n)
		if (!i_rst_n) bad_q <= 1'h0;
		else if (take) bad_q <= i_awaddr > 8'h08 || i_awaddr[1:0] != 2'h0;
	chk_b_delay: assert property (take |-> ##2 o_bvalid)
		else $error("write response late");
	chk_b_resp: assert property ($rose(o_bvalid) |-> o_bresp == (bad_q ? 2'h2 : 2'h0))
		else $error("write response code wrong");
	chk_r_delay: assert property (i_arvalid && o_arready |=> o_rvalid)
		else $error("read response late");
	chk_r_hold: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
		else $error("read data not held");
	chk_do_own: assert property (calm |-> (shd_q[11] ? !o_sdo_oe : (!shd_q[5] || o_sdo_oe)))
		else $error("data pin ownership wrong");
	chk_clk_own: assert property (calm |-> o_sclk_oe == (shd_q[5] && !shd_q[12]))
		else $error("clock pin ownership wrong");
	chk_ss_own: assert property (calm |-> o_ss_in_use == (!shd_q[5] && shd_q[7]))
		else $error("select pin ownership wrong");
	chk_clk_idle: assert property ($rose(calm) |-> o_sclk == shd_q[6])
		else $error("clock idle level wrong");
	cov_slverr: cover property ($rose(o_bvalid) && o_bresp == 2'h2);
	cov_master: cover property (o_sclk_oe && $changed(o_sclk));
	cov_select: cover property (o_ss_in_use);
endmodule : spicc_top_checker

bind spicc_top spicc_top_checker u_chk (.i_clk_sys, .i_rst_n, .i_awvalid, .o_awready,
	.i_awaddr, .i_wvalid, .o_wready, .i_wdata, .o_bvalid, .o_bresp, .i_arvalid, .o_arready,
	.o_rvalid, .i_rready, .o_rdata, .o_sclk, .o_sclk_oe, .o_sdo_oe, .o_ss_in_use);
`default_nettype wire

// file: tb/spicc_peer.sv
// serial peer: slave to the port in master role, clock source in slave role
// assumes the bench sets mode inputs before pulsing i_go
`timescale 1ns/1ps
`default_nettype none
module spicc_peer
(
	input wire logic i_mst,
	input wire logic i_go,
	input wire logic i_cpol,
	input wire logic i_cke,
	input wire logic i_w16,
	input wire logic i_sclk_dut,
	input wire logic i_sdo,
	input wire logic [15:0] i_tx,
	output logic o_sclk,
	output logic o_sdi,
	output logic o_ss_n,
	output logic [15:0] o_rx
);
	logic [15:0] sh;
	logic pend;
	wire act = (i_mst ? o_sclk : i_sclk_dut) ^ i_cpol;
	function automatic void input_sample_phase();
		o_rx = {o_rx[14:0], i_sdo};
		pend = 1'h1;
	endfunction : input_sample_phase
	// a shift only follows a sample, so a change edge that comes before the first sample is skipped
	function automatic void shout();
		if (pend)
		begin
			sh = sh << 1;
			o_sdi = sh[15];
			pend = 1'h0;
		end
	endfunction : shout
	initial
	begin
		o_sclk = 1'h0;
		o_sdi = 1'h0;
		o_ss_n = 1'h1;
	end
	always @(i_cpol) if (o_ss_n) o_sclk = i_cpol;
	always @(posedge act) if (i_cke) input_sample_phase(); else shout();
	always @(negedge act) if (i_cke) shout(); else input_sample_phase();
	always @(posedge i_go)
	begin
		sh = i_w16 ? i_tx : {i_tx[7:0], 8'h00};
		o_sdi = sh[15];
		o_rx = '0;
		pend = 1'h0;
		if (i_mst)
		begin
			#200 o_ss_n = 1'h0;
			repeat (i_w16 ? 16 : 8)
			begin
				#200 o_sclk = ~i_cpol;
				#200 o_sclk = i_cpol;
			end
			#200 o_ss_n = 1'h1;
			o_sdi = ~o_sdi;
		end
	end
endmodule : spicc_peer
`default_nettype wire

// file: tb/spi_control_config_tb.sv
// bench for the serial port: register access over AXI4-Lite and transfers with a peer
// assumes spicc_top, spicc_peer and the checker are compiled before it
`timescale 1ns/1ps
`default_nettype none
module spi_control_config_tb;
	import spicc_pkg::*;
	logic i_clk_sys = 1'h0, i_rst_n = 1'h0, i_awvalid = 1'h0, i_wvalid = 1'h0, i_bready = 1'h0;
	logic i_arvalid = 1'h0, i_rready = 1'h0, cnt_on = 1'h0, p_mst = 1'h0, p_go = 1'h0;
	logic p_cpol = 1'h0, p_cke = 1'h0, p_w16 = 1'h0;
	logic [3:0] i_wstrb = 4'hf;
	logic [15:0] p_tx = '0, p_rx, tx;
	spicc_addr_type i_awaddr = '0, i_araddr = '0;
	spicc_bus_word_type i_wdata = '0, o_rdata;
	logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, i_sclk, o_sclk, o_sclk_oe;
	logic i_sdi, o_sdo, o_sdo_oe, i_ss_n, o_ss_in_use;
	logic [1:0] o_bresp, o_rresp;
	int error_cnt = 0, tests_run = 0, edges = 0;
	always #25 i_clk_sys = ~i_clk_sys;
	always @(o_sclk) if (cnt_on) edges++;
	spicc_top #(.HALF_DIV(4)) dut (.i_clk_sys, .i_rst_n, .i_awvalid, .o_awready, .i_awaddr,
		.i_wvalid, .o_wready, .i_wdata, .i_wstrb, .o_bvalid, .i_bready, .o_bresp, .i_arvalid,
		.o_arready, .i_araddr, .o_rvalid, .i_rready, .o_rdata, .o_rresp, .i_sclk, .o_sclk,
		.o_sclk_oe, .i_sdi, .o_sdo, .o_sdo_oe, .i_ss_n, .o_ss_in_use);
	spicc_peer peer (.i_mst(p_mst), .i_go(p_go), .i_cpol(p_cpol), .i_cke(p_cke), .i_w16(p_w16),
		.i_sclk_dut(o_sclk), .i_sdo(o_sdo), .i_tx(p_tx), .o_sclk(i_sclk), .o_sdi(i_sdi),
		.o_ss_n(i_ss_n), .o_rx(p_rx));
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		tests_run++;
		if (s !== e)
		begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : wrap_up
	// readies are looked at mid-cycle, where they stand for the coming edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ka, kw, kb;
		logic [1:0] r;
		@(posedge i_clk_sys);
		i_awvalid <= 1'h1;
		i_wvalid <= 1'h1;
		i_awaddr <= a;
		i_wdata <= d;
		i_bready <= 1'h1;
		do
		begin
			@(negedge i_clk_sys);
			ka = i_awvalid && o_awready;
			kw = i_wvalid && o_wready;
			kb = o_bvalid;
			r = o_bresp;
			@(posedge i_clk_sys);
			if (ka) i_awvalid <= 1'h0;
			if (kw) i_wvalid <= 1'h0;
		end
		while (!kb);
		i_bready <= 1'h0;
		// registered pins follow the new control word only after this edge settles
		@(negedge i_clk_sys);
		chk("bresp", {30'h0, er}, {30'h0, r});
	endtask : wr
	// rready is raised late on purpose so read data must stand a cycle
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ka, kr, sv;
		@(posedge i_clk_sys);
		i_arvalid <= 1'h1;
		i_araddr <= a;
		do
		begin
			@(negedge i_clk_sys);
			ka = i_arvalid && o_arready;
			kr = o_rvalid && i_rready;
			sv = o_rvalid;
			d = o_rdata;
			r = o_rresp;
			@(posedge i_clk_sys);
			if (ka) i_arvalid <= 1'h0;
			if (sv && !kr) i_rready <= 1'h1;
		end
		while (!kr);
		i_rready <= 1'h0;
	endtask : rd
	task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk("rdata", e, d);
		chk("rresp", {30'h0, er}, {30'h0, r});
	endtask : rc
	task automatic wait_idle;
		logic [31:0] s;
		logic [1:0] r;
		int k;
		k = 0;
		do
		begin
			rd(8'h08, s, r);
			k++;
		end
		while (s[0] !== 1'h0 && k < 300);
		// a word that never finishes counts as a mismatch
		chk("idle", '0, {31'h0, s[0]});
	endtask : wait_idle
	initial
	begin
		#1000000;
		error_cnt++;
		wrap_up();
	end
	initial
	begin
		repeat (5) @(posedge i_clk_sys);
		i_rst_n <= 1'h1;
		rc(8'h00, '0, 2'h0);
		rc(8'h08, '0, 2'h0);
		rc(8'h0c, '0, 2'h2);
		wr(8'h10, 32'hffffffff, 2'h2);
		wr(8'h00, 32'hffffffff, 2'h0);
		rc(8'h00, 32'h00001fff, 2'h0);
		chk("sdo_oe", '0, o_sdo_oe);
		chk("sclk_oe", '0, o_sclk_oe);
		chk("sclk", 32'h1, o_sclk);
		$display("register test done");
		for (int m = 0; m < 8; m++)
		begin
			tx = 16'h3cc3 + 16'(m);
			p_w16 <= m[2];
			p_cke <= m[1];
			p_cpol <= m[0];
			p_tx <= 16'h96e1 - 16'(m);
			wr(8'h00, {21'h0, m[2], 1'h0, m[1], 1'h0, m[0], 6'h20}, 2'h0);
			chk("sclk idle", {31'h0, m[0]}, o_sclk);
			p_go <= 1'h1;
			@(posedge i_clk_sys);
			p_go <= 1'h0;
			edges = 0;
			cnt_on = 1'h1;
			wr(8'h04, {16'h0, tx}, 2'h0);
			wait_idle();
			rc(8'h04, {16'h0, m[2] ? p_tx : {8'h0, p_tx[7:0]}}, 2'h0);
			chk("peer rx", {16'h0, m[2] ? tx : {8'h0, tx[7:0]}}, {16'h0, p_rx});
			cnt_on = 1'h0;
			chk("edges", m[2] ? 32 : 16, edges);
			chk("sclk_oe", 32'h1, o_sclk_oe);
			chk("sdo_oe", 32'h1, o_sdo_oe);
		end
		$display("master test done");
		p_mst <= 1'h1;
		p_cpol <= 1'h0;
		p_cke <= 1'h1;
		p_w16 <= 1'h1;
		p_tx <= 16'hb44d;
		wr(8'h00, 32'h00000580, 2'h0);
		chk("ss use", 32'h1, o_ss_in_use);
		chk("sclk_oe", '0, o_sclk_oe);
		wr(8'h04, 32'h00007e18, 2'h0);
		p_go <= 1'h1;
		@(posedge i_clk_sys);
		p_go <= 1'h0;
		repeat (10) @(posedge i_clk_sys);
		wait_idle();
		rc(8'h04, 32'h0000b44d, 2'h0);
		chk("peer rx", 32'h00007e18, {16'h0, p_rx});
		repeat (20) @(posedge i_clk_sys);
		wr(8'h00, 32'h00000500, 2'h0);
		chk("ss use", '0, o_ss_in_use);
		$display("slave test done");
		wrap_up();
	end
endmodule : spi_control_config_tb
`default_nettype wire
